// [hw/switch_map.svh]
// Constants for the switch input control block: geometry, command
// opcodes, SPI word layout and timing figures.
// Assumes inclusion by bare name from the package and bench files.
`ifndef SWITCH_MAP_SVH
`define SWITCH_MAP_SVH

// Input geometry: ground-switch inputs first, programmable above
`define NUM_GND_IN      14
`define NUM_PROG_IN     8
`define NUM_ALL_IN      22

// Serial word
`define WORD_BITS       24
`define WORD_MSB        23
`define BITCNT_W        5
`define BITCNT_MAX      5'h1F
`define OP_HI           23
`define OP_LO           20
`define ANA_CODE_HI     4
`define ANA_CODE_LO     0
`define ANA_CFG_HI      6
`define ANA_CFG_LO      5
`define ANA_CODE_W      5

// Command opcodes
`define CMD_STATUS      4'h0
`define CMD_SETTINGS    4'h1
`define CMD_MET_PROG    4'h2
`define CMD_MET_GND     4'h3
`define CMD_TDIS_PROG   4'h4
`define CMD_TDIS_GND    4'h5
`define CMD_TRI_PROG    4'h6
`define CMD_TRI_GND     4'h7
`define CMD_ANALOG      4'h8

// Reset values
`define TRI_RST         22'h3FFFFF
`define MASK_RST        22'h000000
`define BAT_RST         8'h00
`define ANA_CODE_RST    5'h00

// Timing
`define WET_TIME_MS     20
`define CLK_FREQ_KHZ    100000

`endif

// [hw/switch_pkg.sv]
// Types shared by the switch input control block.
// Assumes switch_map.svh sits on the include path.
`include "switch_map.svh"

package switch_pkg;

   typedef enum logic [1:0] {
      ANA_HIZ  = 2'b00,
      ANA_LOW  = 2'b01,
      ANA_HIGH = 2'b10
   } ana_cfg_e;

   typedef logic [`OP_HI-`OP_LO:0] opcode_t;
   typedef logic [`NUM_ALL_IN-1:0] in_mask_t;

endpackage

// [hw/sync2.sv]
// Two-stage synchroniser for a bus of independent level signals.
// Assumes each bit is a separate level; no word coherence is given.
`timescale 1ns/1ps

module sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_ff;
   logic [W-1:0] hold_ff;

   ////////////////////////////////////////////////////////////////////
   // One flop pair per bit; stage one feeds stage two only
   genvar b;
   generate
      for (b = 0; b < W; b++) begin : g_bit
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               meta_ff[b] <= 1'b0;
               hold_ff[b] <= 1'b0;
            end else begin
               meta_ff[b] <= d[b];
               hold_ff[b] <= meta_ff[b];
            end
         end
      end
   endgenerate

   assign q = hold_ff;

endmodule

// [hw/switch_ctrl.sv]
// Control logic of a 22-input switch detection interface: SPI command
// slave, per-input current source steering, wetting timers, analog
// select and thermal protection.
// Assumes pins, SPI lines and the thermal comparator are asynchronous;
// normal_mode comes from logic on clk; sys_rst is the power-on reset.
//
// How it works
// - Thermal protection acts only while the device is in Normal mode.
// - Over temperature raises interrupt, forces sustain current, rest runs.
// - Over temperature sets thermal flag carried in every SO word.
// - Thermal flag clears at CS rise only once die has cooled.
// - After cooling, previously programmed wetting currents come back.
// - Metallic input with timer gets high current for window after closing.
// - Timer disabled: wetting current stays on while switch is closed.
// - Analog command code selects input, applied at CS rising edge.
// - Analog-selected input reads as zero in next SO word.
// - Analog input may be high impedance, low or high pull-up.
// - Power-up in Normal mode with every input tri-stated.
// - Programmable input sinks when to-battery, sources when to-ground.
// - Ground-switch input source follows the tri-state control.
// - Tri-stated ground input pulled low reports one, open load.
// - Configuration commands are taken only in Normal mode.
// - Interrupt output stays low until host reads switch status.
`timescale 1ns/1ps

module switch_ctrl
   import switch_pkg::*;
#(
   parameter int NUM_IN     = `NUM_ALL_IN,
   parameter int NUM_GND    = `NUM_GND_IN,
   parameter int WET_CYCLES = `WET_TIME_MS * `CLK_FREQ_KHZ
) (
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic              normal_mode,
   input  wire logic              over_temp,
   input  wire logic              sck,
   input  wire logic              cs_n,
   input  wire logic              si,
   output logic                   so,
   output logic                   so_oe,
   output logic                   int_n,
   input  wire logic [NUM_IN-1:0] pin_low,
   output logic      [NUM_IN-1:0] src_en,
   output logic      [NUM_IN-1:0] sink_en,
   output logic      [NUM_IN-1:0] high_cur,
   output logic                   analog_select_en,
   output logic [`ANA_CODE_W-1:0] analog_select_output
);

   localparam int CW = $clog2(WET_CYCLES + 1);
   localparam int NP = NUM_IN - NUM_GND;

   ////////////////////////////////////////////////////////////////////
   // Synchronisers
   logic [NUM_IN+3:0] syncd;
   logic              ot_s;
   logic              sck_s;
   logic              cs_s;
   logic              si_s;
   logic [NUM_IN-1:0] low_s;

   sync2 #(
      .W (NUM_IN + 4)
   ) u_sync (
      .clk     (clk),
      .sys_rst (sys_rst),
      .d       ({over_temp, sck, ~cs_n, si, pin_low}),
      .q       (syncd)
   );

   assign ot_s  = syncd[NUM_IN+3];
   assign sck_s = syncd[NUM_IN+2];
   assign cs_s  = ~syncd[NUM_IN+1];  // Inverted so reset reads idle
   assign si_s  = syncd[NUM_IN];
   assign low_s = syncd[NUM_IN-1:0];

   ////////////////////////////////////////////////////////////////////
   // SPI framing
   logic                  sck_prev_ff;
   logic                  cs_prev_ff;
   logic [`WORD_MSB:0]    shin_ff;
   logic [`WORD_MSB:0]    shout_ff;
   logic [`BITCNT_W-1:0]  bitcnt_ff;
   logic                  so_oe_ff;
   logic                  sck_rise;
   logic                  sck_fall;
   logic                  cs_fall;
   logic                  cs_rise;
   logic                  word_ok;
   logic                  cmd_take;
   logic                  rd_ack;
   opcode_t               opcode;
   logic [`WORD_MSB:0]    so_word;
   logic [`BITCNT_W-1:0]  nxt_bitcnt;

   assign sck_rise = sck_s & ~sck_prev_ff & ~cs_s;
   assign sck_fall = ~sck_s & sck_prev_ff & ~cs_s;
   assign cs_fall  = ~cs_s & cs_prev_ff;
   assign cs_rise  = cs_s & ~cs_prev_ff;
   // Short or long frames are dropped whole, never half applied
   assign word_ok  = (bitcnt_ff == `BITCNT_W'(`WORD_BITS));
   assign opcode   = shin_ff[`OP_HI:`OP_LO];
   assign cmd_take = cs_rise & word_ok & normal_mode;
   assign rd_ack   = cmd_take & (opcode == `CMD_STATUS);
   assign nxt_bitcnt = (bitcnt_ff == `BITCNT_MAX) ? bitcnt_ff
                                                  : bitcnt_ff + 1'b1;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sck_prev_ff <= 1'b0;
         cs_prev_ff  <= 1'b1;
         bitcnt_ff   <= '0;
         shin_ff     <= '0;
      end else begin
         sck_prev_ff <= sck_s;
         cs_prev_ff  <= cs_s;
         if (cs_fall) begin
            bitcnt_ff <= '0;
         end else if (sck_rise) begin
            bitcnt_ff <= nxt_bitcnt;
            shin_ff   <= {shin_ff[`WORD_MSB-1:0], si_s};
         end
      end
   end

   // Output word loaded at CS fall, first bit valid before first SCK
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         shout_ff <= '0;
         so_oe_ff <= 1'b0;
      end else begin
         so_oe_ff <= ~cs_s;
         if (cs_fall) begin
            shout_ff <= so_word;
         end else if (sck_fall) begin
            shout_ff <= {shout_ff[`WORD_MSB-1:0], 1'b0};
         end
      end
   end

   assign so    = shout_ff[`WORD_MSB];
   assign so_oe = so_oe_ff;

   ////////////////////////////////////////////////////////////////////
   // Configuration registers
   in_mask_t              tri_ff;
   in_mask_t              met_ff;
   in_mask_t              tdis_ff;
   logic [NP-1:0]         bat_ff;
   logic [`ANA_CODE_W-1:0] ana_code_ff;
   ana_cfg_e              ana_cfg_ff;
   logic                  ana_en_ff;
   logic [`ANA_CODE_W-1:0] ana_code_in;
   logic                  ana_code_ok;

   // Replace one group of a mask, leave the other group alone
   function automatic in_mask_t grp_write(input in_mask_t old,
                                          input logic prog,
                                          input logic [`WORD_MSB:0] w);
      in_mask_t r;
      r = old;
      if (prog) begin
         r[NUM_IN-1:NUM_GND] = w[NP-1:0];
      end else begin
         r[NUM_GND-1:0] = w[NUM_GND-1:0];
      end
      return r;
   endfunction

   assign ana_code_in = shin_ff[`ANA_CODE_HI:`ANA_CODE_LO];
   assign ana_code_ok = (ana_code_in != '0) &&
                        (ana_code_in <= `ANA_CODE_W'(NUM_IN));

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tri_ff      <= `TRI_RST;
         met_ff      <= `MASK_RST;
         tdis_ff     <= `MASK_RST;
         bat_ff      <= `BAT_RST;
         ana_code_ff <= `ANA_CODE_RST;
         ana_cfg_ff  <= ANA_HIZ;
         ana_en_ff   <= 1'b0;
      end else if (cmd_take) begin
         unique case (opcode)
            `CMD_SETTINGS:  bat_ff  <= shin_ff[NP-1:0];
            `CMD_MET_PROG:  met_ff  <= grp_write(met_ff, 1'b1, shin_ff);
            `CMD_MET_GND:   met_ff  <= grp_write(met_ff, 1'b0, shin_ff);
            `CMD_TDIS_PROG: tdis_ff <= grp_write(tdis_ff, 1'b1, shin_ff);
            `CMD_TDIS_GND:  tdis_ff <= grp_write(tdis_ff, 1'b0, shin_ff);
            `CMD_TRI_PROG:  tri_ff  <= grp_write(tri_ff, 1'b1, shin_ff);
            `CMD_TRI_GND:   tri_ff  <= grp_write(tri_ff, 1'b0, shin_ff);
            `CMD_ANALOG: begin
               ana_code_ff <= ana_code_in;
               ana_en_ff   <= ana_code_ok;
               ana_cfg_ff  <= ana_cfg_e'(shin_ff[`ANA_CFG_HI:`ANA_CFG_LO]);
            end
            default: ;
         endcase
      end
   end

   assign analog_select_output = ana_code_ff;
   assign analog_select_en     = ana_en_ff;

   ////////////////////////////////////////////////////////////////////
   // Thermal protection and interrupt
   logic therm_on;
   logic therm_prev_ff;
   logic therm_flag_ff;
   logic por_flag_ff;
   logic int_pend_ff;
   logic int_n_ff;
   logic sw_change;
   logic int_set;
   logic nxt_flag;
   logic nxt_pend;
   in_mask_t closed;
   in_mask_t closed_prev_ff;

   assign therm_on  = normal_mode & ot_s;
   assign sw_change = normal_mode & (|(closed ^ closed_prev_ff));
   assign int_set   = (therm_on & ~therm_prev_ff) | sw_change;
   // Set beats clear; clear needs a cool die
   // flag set
   assign nxt_flag  = therm_on | (therm_flag_ff & ~(cs_rise & ~ot_s));
   assign nxt_pend  = int_set | (int_pend_ff & ~rd_ack);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         therm_prev_ff  <= 1'b0;
         therm_flag_ff  <= 1'b0;
         por_flag_ff    <= 1'b1;
         int_pend_ff    <= 1'b0;
         int_n_ff       <= 1'b1;
         closed_prev_ff <= '0;
      end else begin
         therm_prev_ff  <= therm_on;
         therm_flag_ff  <= nxt_flag;
         por_flag_ff    <= por_flag_ff & ~rd_ack;
         int_pend_ff    <= nxt_pend;
         int_n_ff       <= ~nxt_pend;
         closed_prev_ff <= closed;
      end
   end
   assign int_n = int_n_ff;

   ////////////////////////////////////////////////////////////////////
   // Per-input status and current steering
   logic [CW-1:0] wet_cnt_ff [NUM_IN];
   in_mask_t      so_bits;
   in_mask_t      src_ff;
   in_mask_t      sink_ff;
   in_mask_t      hi_ff;

   genvar i;
   generate
      for (i = 0; i < NUM_IN; i++) begin : g_in
         logic is_prog;
         logic to_bat;
         logic sel_hit;
         logic wet_hi;
         logic nxt_src;
         logic nxt_sink;
         logic nxt_hi;

         assign is_prog = (i >= NUM_GND);
         if (i >= NUM_GND) begin : g_prog
            assign to_bat = bat_ff[i-NUM_GND];
         end else begin : g_gnd
            assign to_bat = 1'b0;
         end

         // Pin low reads closed even when tri-stated, except on a to-battery input
         // open load bit
         assign closed[i]  = is_prog ? (low_s[i] ^ to_bat) : low_s[i];
         assign sel_hit    = ana_en_ff &&
                             (ana_code_ff == `ANA_CODE_W'(i + 1));
         assign so_bits[i] = closed[i] & ~sel_hit;

         assign wet_hi = tdis_ff[i] ? closed[i]
                                    : (wet_cnt_ff[i] != '0);

         // Settings kept; heat only masks the high level
         // forced sustain
         assign nxt_src  = sel_hit ? (ana_cfg_ff != ANA_HIZ)
                                   : (~tri_ff[i] & ~to_bat);
         assign nxt_sink = ~sel_hit & ~tri_ff[i] & to_bat;
         assign nxt_hi   = ~therm_on &
                           (sel_hit ? (ana_cfg_ff == ANA_HIGH)
                                    : (met_ff[i] & wet_hi));

         always_ff @(posedge clk) begin
            if (sys_rst) begin
               wet_cnt_ff[i] <= '0;
               src_ff[i]     <= 1'b0;
               sink_ff[i]    <= 1'b0;
               hi_ff[i]      <= 1'b0;
            end else begin
               if (!closed[i]) begin
                  wet_cnt_ff[i] <= '0;
               end else if (!closed_prev_ff[i]) begin
                  wet_cnt_ff[i] <= CW'(WET_CYCLES);
               end else if (wet_cnt_ff[i] != '0) begin
                  wet_cnt_ff[i] <= wet_cnt_ff[i] - 1'b1;
               end
               src_ff[i]  <= nxt_src;
               sink_ff[i] <= nxt_sink;
               hi_ff[i]   <= nxt_hi;
            end
         end
      end
   endgenerate

   assign so_word  = {therm_flag_ff, por_flag_ff, so_bits};
   assign src_en   = src_ff;
   assign sink_en  = sink_ff;
   assign high_cur = hi_ff;

endmodule

// [verification/switch_ctrl_monitor.sv]
// Port-level property checker for switch_ctrl.
// Assumes it is bound to switch_ctrl and that everything runs on clk.
`timescale 1ns/1ps

module switch_ctrl_monitor #(
   parameter int NUM_IN  = 22,
   parameter int NUM_GND = 14
) (
   input wire logic              clk,
   input wire logic              sys_rst,
   input wire logic              normal_mode,
   input wire logic              over_temp,
   input wire logic              cs_n,
   input wire logic              so,
   input wire logic              so_oe,
   input wire logic              int_n,
   input wire logic [NUM_IN-1:0] src_en,
   input wire logic [NUM_IN-1:0] sink_en,
   input wire logic [NUM_IN-1:0] high_cur,
   input wire logic              analog_select_en,
   input wire logic [4:0]        analog_select_output
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   ///////////////////////////////////////////////////////////////
   AST_RST_OFF: assert property ($fell(sys_rst) |->
      src_en == '0 && sink_en == '0 && int_n && !so_oe)
      else $error("outputs not idle after reset");
   AST_NORM_ONLY: assert property ((!normal_mode)[*4] |->
      $stable(int_n)) else $error("interrupt moved outside normal mode");
   AST_HOT_INT: assert property ((cs_n && normal_mode)[*4] ##0
      $rose(over_temp) ##1 (cs_n && normal_mode && over_temp)[*6]
      |-> !int_n) else $error("no interrupt on over temperature");
   AST_HOT_CUR: assert property ((normal_mode && over_temp)[*7]
      |-> high_cur == '0) else $error("high current while hot");
   AST_FLAG_SO: assert property ((normal_mode && over_temp)[*8]
      ##0 $rose(so_oe) |-> so) else $error("thermal flag missing");
   AST_INT_HOLD: assert property (cs_n[*8] ##0 !int_n |=>
      !int_n) else $error("interrupt dropped without a read");
   // Reset may move the code; only a finished frame may otherwise
   AST_MUX_AT_CS: assert property (!$past(sys_rst) &&
      $changed(analog_select_output) |-> cs_n && $past(cs_n, 3))
      else $error("mux changed inside a frame");
   AST_NO_FIGHT: assert property (!analog_select_en |->
      (src_en & sink_en) == '0) else $error("source and sink both on");
   AST_GND_NO_SINK: assert property (sink_en[NUM_GND-1:0] == '0)
      else $error("ground input sinking");
   AST_OE_TRACK: assert property ($stable(cs_n)[*4] |->
      so_oe == !cs_n) else $error("output enable off its frame");
   cover property (!int_n ##1 int_n);
   cover property ($rose(analog_select_en));
   cover property ($rose(|sink_en));
endmodule

bind switch_ctrl switch_ctrl_monitor #(.NUM_IN(NUM_IN), .NUM_GND(NUM_GND))
   mon (.clk(clk), .sys_rst(sys_rst), .normal_mode(normal_mode),
   .over_temp(over_temp), .cs_n(cs_n), .so(so), .so_oe(so_oe),
   .int_n(int_n), .src_en(src_en), .sink_en(sink_en),
   .high_cur(high_cur), .analog_select_en(analog_select_en),
   .analog_select_output(analog_select_output));

// [verification/spi_host_model.sv]
// Host microcontroller side of the SPI link: mode 0, MSB first.
// Assumes clk of 10 ns; sck half period of 8 clk gives 80 ns.
`timescale 1ns/1ps

module spi_host_model (
   input  wire logic clk,
   output logic      sck,
   output logic      cs_n,
   output logic      si,
   input  wire logic so
);
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Sck rests low between frames; si never keeps a stale bit
   task automatic xfer(input logic [23:0] w, input int bits,
                       output logic [23:0] r);
      r = 24'h000000;
      tick(1);
      cs_n = 1'b0;
      for (int i = bits - 1; i >= 0; i--) begin
         si = w[i];
         tick(8);
         sck = 1'b1;
         r = {r[22:0], so};
         tick(8);
         sck = 1'b0;
      end
      tick(8);
      cs_n = 1'b1;
      si = ~si;
      tick(12);
   endtask
endmodule

// [verification/test_switch_input_thermal_and_drive_control.sv]
// Bench for switch_ctrl: host model sends commands, pins driven here.
// Assumes switch_map.svh on the include path; wetting window shortened.
`timescale 1ns/1ps
`include "switch_map.svh"

`define CHK(got, exp) begin \
   checks++; \
   if ((got) !== (exp)) begin \
      mismatches++; \
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); \
   end \
end

module test_switch_input_thermal_and_drive_control import switch_pkg::*;;
   localparam int WET = 50;
   logic        clk, sys_rst, normal_mode, over_temp, flag, por;
   logic        sck, cs_n, si, so, so_oe, int_n, ana_en;
   logic [4:0]  ana_code, sel, code;
   in_mask_t    pin_low, src_en, sink_en, high_cur;
   logic [7:0]  bat;
   logic [19:0] m;
   logic [23:0] rx, ex;
   int          mismatches, checks, j, g, rs;

   switch_ctrl #(.WET_CYCLES(WET)) DUT (.clk(clk), .sys_rst(sys_rst),
      .normal_mode(normal_mode), .over_temp(over_temp), .sck(sck),
      .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe), .int_n(int_n),
      .pin_low(pin_low), .src_en(src_en), .sink_en(sink_en),
      .high_cur(high_cur), .analog_select_en(ana_en),
      .analog_select_output(ana_code));
   spi_host_model host (.clk(clk), .sck(sck), .cs_n(cs_n), .si(si),
      .so(so));
   ///////////////////////////////////////////////////////////////
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   function automatic logic [23:0] exp_word();
      in_mask_t st;
      st = pin_low ^ {bat, 14'h0000};
      if (sel != 5'h00) st[sel - 5'h01] = 1'b0;
      return {flag, por, st};
   endfunction

   // Word seen is the one loaded at select fall, before the update
   task automatic cmd(input opcode_t op, input logic [19:0] d);
      ex = exp_word();
      host.xfer({op, d}, 24, rx);
      if (!over_temp) flag = 1'b0;
      if (op == `CMD_STATUS) por = 1'b0;
      if (op == `CMD_SETTINGS) bat = d[7:0];
      if (op == `CMD_ANALOG) sel = d[4:0];
   endtask

   task automatic rd();
      cmd(`CMD_STATUS, 20'h00000);
      `CHK(rx, ex)
   endtask

   task automatic wait_int();
      int n;
      n = 0;
      while (int_n !== 1'b0 && n < 20) begin
         step(1);
         n++;
      end
      `CHK(int_n, 1'b0)
      if (n == 20) wrap_up();
   endtask

   task automatic wrap_up();
      $display("checks=%0d mismatches=%0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial begin
      repeat (100000) @(posedge clk);
      mismatches++;
      wrap_up();
   end

   initial begin
      sys_rst = 1'b1; normal_mode = 1'b1; over_temp = 1'b0;
      pin_low = '0; mismatches = 0; checks = 0; por = 1'b1;
      bat = 8'h00; sel = 5'h00; flag = 1'b0;
      rs = $urandom(32'h855BE231);
      step(2);
      sys_rst = 1'b0;
      step(4);
      `CHK(src_en | sink_en, 22'h000000)
      for (int i = 0; i < 4; i++) begin
         pin_low = pin_low ^ (in_mask_t'($urandom) | 22'h000001);
         wait_int();
         rd();
         `CHK(int_n, 1'b1)
      end
      j = 14 + ($urandom % 8);
      m = 20'(1 << (j - 14));
      cmd(`CMD_TDIS_PROG, m);
      cmd(`CMD_MET_PROG, m);
      cmd(`CMD_SETTINGS, m);
      cmd(`CMD_TRI_PROG, 20'h000FF ^ m);
      `CHK({sink_en[j], src_en[j]}, 2'h2)
      cmd(`CMD_SETTINGS, 20'h00000);
      `CHK({sink_en[j], src_en[j]}, 2'h1)
      pin_low[j] = 1'b1;
      step(2 * WET);
      `CHK(high_cur[j], 1'b1)
      g = $urandom % 14;
      m = 20'(1 << g);
      cmd(`CMD_TDIS_GND, m);
      cmd(`CMD_MET_GND, m);
      cmd(`CMD_TRI_GND, 20'h03FFF ^ m);
      `CHK(src_en[g], 1'b1)
      cmd(`CMD_TRI_GND, 20'h03FFF);
      `CHK(src_en[g], 1'b0)
      pin_low[g] = 1'b1;
      step(5);
      rd();
      cmd(`CMD_TDIS_GND, 20'h00000);
      cmd(`CMD_TRI_GND, 20'h03FFF ^ m);
      pin_low[g] = 1'b0;
      step(WET + 10);
      pin_low[g] = 1'b1;
      step(8);
      `CHK(high_cur[g], 1'b1)
      step(WET + 4);
      `CHK(high_cur[g], 1'b0)
      rd();
      over_temp = 1'b1;
      flag = 1'b1;
      step(10);
      `CHK({high_cur[j], int_n}, 2'h0)
      rd();
      rd();
      over_temp = 1'b0;
      step(6);
      `CHK(high_cur[j], 1'b1)
      rd();
      rd();
      normal_mode = 1'b0;
      over_temp = 1'b1;
      step(10);
      `CHK({high_cur[j], int_n}, 2'h3)
      host.xfer({`CMD_SETTINGS, 20'h000FF}, 24, rx);
      `CHK(sink_en[j], 1'b0)
      over_temp = 1'b0;
      step(4);
      normal_mode = 1'b1;
      host.xfer({`CMD_SETTINGS, 20'h000FF}, 23, rx);
      `CHK(sink_en[j], 1'b0)
      pin_low = '1;
      step(5);
      for (int c = 0; c < 3; c++) begin
         code = 5'(1 + $urandom % 22);
         cmd(`CMD_ANALOG, {13'h0000, 2'(c), code});
         `CHK({ana_en, ana_code}, {1'b1, code})
         `CHK(src_en[code - 5'h01], c != 0)
         `CHK(high_cur[code - 5'h01], c == 2)
         rd();
      end
      cmd(`CMD_ANALOG, 20'h00000);
      `CHK(ana_en, 1'b0)
      wrap_up();
   end
endmodule
